// [rtl/rfs_params.svh]
// Constants for the CPU core register set: widths, bus offsets, flag layout.
`ifndef RFS_PARAMS_SVH
`define RFS_PARAMS_SVH

// Register widths
`define RFS_DW          16
`define RFS_AW          24
`define RFS_MW          8
`define RFS_BUS_W       32
`define RFS_SEL_W       4
`define RFS_ADR_W       8
// Banked storage: 8 words per bank, two banks
`define RFS_BANK_AW     4
`define RFS_NUM_DATA    4
// Wishbone byte offsets, banked window is 0x00..0x1C
`define RFS_BANK_WIN    3'h0
`define RFS_PAIR_WIN    5'h04
`define RFS_OFF_IP      8'h28
`define RFS_OFF_VTB     8'h2C
`define RFS_OFF_USP     8'h30
`define RFS_OFF_ISP     8'h34
`define RFS_OFF_FLAG    8'h38
`define RFS_OFF_SVF     8'h3C
`define RFS_OFF_SVP     8'h40
`define RFS_OFF_VCT     8'h44
`define RFS_OFF_ASP     8'h48
// Transfer channel window: 0x80 + 0x20 * channel
`define RFS_DMA_WIN     2'h2
`define RFS_FLD_MODE    3'h0
`define RFS_FLD_COUNT   3'h1
`define RFS_FLD_RELOAD  3'h2
`define RFS_FLD_MEM     3'h3
`define RFS_FLD_FIXED   3'h4
// Flag word layout
`define RFS_FLAG_IMPL   16'h70FF
`define RFS_FLAG_BANK   4
`define RFS_FLAG_STACK  7
// Reset values
`define RFS_RST_DATA    16'h0000
`define RFS_RST_ADDR    24'h000000
`define RFS_RST_MODE    8'h00
`define RFS_RST_BUS     32'h00000000

`endif

// [rtl/rfs_pkg.sv]
// Types shared by the CPU core register set.
`include "rfs_params.svh"
`default_nettype none

package rfs_pkg;

    // Classic Wishbone request from the master
    typedef struct packed {
        logic                    cyc;
        logic                    stb;
        logic                    we;
        logic [`RFS_SEL_W-1:0]   sel;
        logic [`RFS_ADR_W-1:0]   adr;
        logic [`RFS_BUS_W-1:0]   dat;
    } rfs_wb_req_t;

    // Per-channel transfer registers
    typedef struct packed {
        logic [`RFS_MW-1:0]      mode;
        logic [`RFS_DW-1:0]      count;
        logic [`RFS_DW-1:0]      reload;
        logic [`RFS_AW-1:0]      mem_ptr;
        logic [`RFS_AW-1:0]      fixed_ptr;
    } rfs_xfer_t;

    // Bus sequencer, Gray along idle-read-pair-answer
    typedef enum logic [1:0] {
        RFS_IDLE = 2'h0,
        RFS_READ = 2'h1,
        RFS_PAIR = 2'h3,
        RFS_ANS  = 2'h2
    } rfs_bus_st_t;

endpackage

`default_nettype wire

// [rtl/rfs_bank_mem.sv]
// Banked register storage: bit-masked write port, two registered read ports.
`include "rfs_params.svh"
`default_nettype none

module rfs_bank_mem #(
    parameter int WIDTH = `RFS_AW,
    parameter int AW    = `RFS_BANK_AW
) (
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic             we,
    input  wire logic [AW-1:0]    waddr,
    input  wire logic [WIDTH-1:0] wdata,
    input  wire logic [WIDTH-1:0] wmask,
    input  wire logic [AW-1:0]    raddr_a,
    output logic      [WIDTH-1:0] rdata_a,
    input  wire logic [AW-1:0]    raddr_b,
    output logic      [WIDTH-1:0] rdata_b
);

    logic [WIDTH-1:0] mem_q [2**AW];
    logic [WIDTH-1:0] mem_d [2**AW];

    // Only masked bits change, so byte halves never disturb each other
    always_comb begin
        mem_d = mem_q;
        if (we) begin
            mem_d[waddr] = (mem_q[waddr] & ~wmask) | (wdata & wmask);
        end
    end

    // Storage is cleared at reset; reads return the value before a same-cycle write
    always_ff @(posedge clk) begin
        if (!rstn) begin
            for (int i = 0; i < 2**AW; i++) begin
                mem_q[i] <= '0;
            end
            rdata_a <= '0;
            rdata_b <= '0;
        end else begin
            mem_q   <= mem_d;
            rdata_a <= mem_q[raddr_a];
            rdata_b <= mem_q[raddr_b];
        end
    end

endmodule

`default_nettype wire

// [rtl/rfs_core_regs.sv]
// CPU core register set: banked general registers, control, fast-interrupt and transfer registers.
//
// Summary of operation
// RQ1: Two full copies of data, pointer, frame and static base; one active.
// RQ2: Bank flag clear selects copy zero, set selects copy one.
// RQ3: Four 16-bit data registers acc_word_a to acc_word_d.
// RQ4: acc_word_a and acc_word_b byte halves writable independently.
// RQ5: acc_word_c over a and acc_word_d over b form 32-bit pairs.
// RQ6: Two 24-bit pointer registers, also bases for indirect addressing.
// RQ7: 24-bit frame base register for frame-relative addressing.
// RQ8: 24-bit static base register for static-relative addressing.
// RQ9: 24-bit instruction pointer holds next instruction address.
// RQ10: 24-bit vector table base register.
// RQ11: Two 24-bit stack pointers chosen by flag word bit 7.
// RQ12: Stack flag one selects user pointer, zero selects interrupt pointer.
// RQ13: Flag word has 11 implemented bits, rest read zero.
// RQ14: Fast interrupt copies flag word into saved flags.
// RQ15: Fast interrupt copies instruction pointer into saved pointer.
// RQ16: 24-bit fast interrupt target becomes jump destination.
// RQ17: Each transfer channel has an 8-bit mode register.
// RQ18: Each channel has a 16-bit transfer count register.
// RQ19: Each channel has a 16-bit reload register refilling the count.
// RQ20: Each channel has a 24-bit memory pointer register.
// RQ21: Each channel has a 24-bit fixed peripheral address register.
// RQ22: Reset clears general, control, flag and mode registers; others undefined.
// RQ23: Banked accesses reach only the selected copy; other copy untouched.
//
// Register access over Wishbone and the register addresses were left to the implementer.
`include "rfs_params.svh"
`default_nettype none

module rfs_core_regs
    import rfs_pkg::*;
#(
    parameter int NCH = 2
) (
    input  wire logic                    clk,
    input  wire logic                    rstn,
    input  wire rfs_wb_req_t             wb_req,
    output logic                         wb_ack_o,
    output logic      [`RFS_BUS_W-1:0]   wb_dat_o,
    input  wire logic                    core_fint,
    input  wire logic                    core_ip_we,
    input  wire logic [`RFS_AW-1:0]      core_ip_d,
    input  wire logic                    core_flag_we,
    input  wire logic [`RFS_DW-1:0]      core_flag_d,
    input  wire logic [2:0]              core_rd_idx,
    input  wire logic [NCH-1:0]          core_xfer_reload,
    output logic      [`RFS_AW-1:0]      core_rd_data,
    output logic      [`RFS_AW-1:0]      instruction_pointer,
    output logic      [`RFS_AW-1:0]      vector_table_base,
    output logic      [`RFS_AW-1:0]      active_stack_ptr,
    output logic      [`RFS_DW-1:0]      flag_word,
    output logic                         bank_sel,
    output rfs_xfer_t [NCH-1:0]          xfer_o
);

    // Narrowing widths for merged register writes
    localparam int DW = `RFS_DW;
    localparam int MW = `RFS_MW;

    // Bus decode
    logic [`RFS_ADR_W-1:0]   adr;
    logic                    req;
    logic                    in_bank;
    logic                    is_pair;
    logic                    is_dma;
    logic [`RFS_BUS_W-1:0]   bmask;
    logic [2:0]              pair_lo_idx;
    logic [2:0]              pair_hi_idx;
    logic [`RFS_AW-1:0]      wr_dat, wr_msk;

    // Bus sequencer state
    rfs_bus_st_t             st_q;
    rfs_bus_st_t             st_d;
    logic                    ack_q;
    logic                    ack_d;
    logic [`RFS_BUS_W-1:0]   dat_q;
    logic [`RFS_BUS_W-1:0]   dat_d;
    logic [`RFS_AW-1:0]      hold_q;
    logic [`RFS_AW-1:0]      hold_d;
    logic                    commit;
    logic [`RFS_BUS_W-1:0]   rd_val;
    rfs_xfer_t               dma_sel;

    // Banked storage ports
    logic                    mem_we;
    logic [`RFS_BANK_AW-1:0] mem_wa;
    logic [`RFS_AW-1:0]      mem_wd;
    logic [`RFS_AW-1:0]      mem_wm;
    logic [`RFS_BANK_AW-1:0] mem_ra;
    logic [`RFS_AW-1:0]      mem_rd;

    // Unbanked core registers
    logic [`RFS_AW-1:0]      ip_q,  ip_d;
    logic [`RFS_AW-1:0]      vtb_q, vtb_d;
    logic [`RFS_AW-1:0]      user_stack_ptr_q, user_stack_ptr_d;
    logic [`RFS_AW-1:0]      irq_stack_ptr_q, irq_stack_ptr_d;
    logic [`RFS_AW-1:0]      asp_q, asp_d;
    logic [`RFS_DW-1:0]      flag_q, flag_d;
    logic [`RFS_DW-1:0]      saved_flags_q, saved_flags_d;
    logic [`RFS_AW-1:0]      saved_pointer_q, saved_pointer_d;
    logic [`RFS_AW-1:0]      fast_irq_target_q, fast_irq_target_d;

    // Keep unchanged bits, replace the bits enabled by the byte selects
    function automatic logic [`RFS_AW-1:0] merge(input logic [`RFS_AW-1:0] old_v, new_v, msk);
        merge = (old_v & ~msk) | (new_v & msk);
    endfunction

    // Address classes and byte-select expansion
    assign adr         = wb_req.adr;
    assign req         = wb_req.cyc & wb_req.stb;
    assign in_bank     = (adr[7:5] == `RFS_BANK_WIN);
    assign is_pair     = (adr[7:3] == `RFS_PAIR_WIN);
    assign is_dma      = (adr[7:6] == `RFS_DMA_WIN);
    assign pair_lo_idx = {2'h0, adr[2]};
    assign pair_hi_idx = {2'h1, adr[2]};
    assign wr_dat      = wb_req.dat[`RFS_AW-1:0];
    assign wr_msk      = bmask[`RFS_AW-1:0];
    always_comb begin
        for (int i = 0; i < `RFS_SEL_W; i++) begin
            bmask[8*i +: 8] = {8{wb_req.sel[i]}};
        end
    end

    // Selected bank is always the top address bit of storage
    always_comb begin
        if (st_q == RFS_READ && is_pair) begin
            mem_ra = {bank_sel, pair_hi_idx}; // RQ5
        end else if (is_pair) begin
            mem_ra = {bank_sel, pair_lo_idx}; // RQ5
        end else begin
            mem_ra = {bank_sel, adr[4:2]}; // RQ2 RQ23
        end
    end

    // Banked writes; a pair writes its low word first, then its high word
    always_comb begin
        mem_we = 1'b0;
        mem_wa = {bank_sel, adr[4:2]}; // RQ23
        mem_wd = wr_dat;
        mem_wm = wr_msk;
        if (adr[4:2] < 3'(`RFS_NUM_DATA)) begin
            mem_wm = {8'h00, bmask[`RFS_DW-1:0]}; // RQ3 RQ4
        end
        if (req && wb_req.we) begin
            if (st_q == RFS_READ && in_bank) begin
                mem_we = 1'b1; // RQ1
            end else if (st_q == RFS_READ && is_pair) begin
                mem_we = 1'b1;
                mem_wa = {bank_sel, pair_lo_idx};
                mem_wd = {8'h00, wb_req.dat[`RFS_DW-1:0]}; // RQ5
            end else if (st_q == RFS_PAIR) begin
                mem_we = 1'b1;
                mem_wa = {bank_sel, pair_hi_idx};
                mem_wd = {8'h00, wb_req.dat[`RFS_BUS_W-1:`RFS_DW]}; // RQ5
                mem_wm = {8'h00, bmask[`RFS_BUS_W-1:`RFS_DW]};
            end
        end
    end

    // Two banks of eight words; the unselected bank is never addressed
    rfs_bank_mem #(
        .WIDTH (`RFS_AW),
        .AW    (`RFS_BANK_AW)
    ) u_bank (
        .clk     (clk),
        .rstn    (rstn),
        .we      (mem_we),
        .waddr   (mem_wa),
        .wdata   (mem_wd),
        .wmask   (mem_wm),
        .raddr_a (mem_ra),
        .rdata_a (mem_rd),
        .raddr_b ({bank_sel, core_rd_idx}),
        .rdata_b (core_rd_data)
    ); // RQ1 RQ6 RQ7 RQ8

    // Read data for the transfer channel being addressed
    assign dma_sel = xfer_o[adr[5]];

    // Read multiplexer; unmapped offsets read zero
    always_comb begin
        rd_val = `RFS_RST_BUS;
        if (in_bank) begin
            rd_val = {8'h00, mem_rd};
        end else if (is_pair) begin
            rd_val = {mem_rd[`RFS_DW-1:0], hold_q[`RFS_DW-1:0]}; // RQ5
        end else if (is_dma) begin
            unique case (adr[4:2])
                `RFS_FLD_MODE:   rd_val = {24'h000000, dma_sel.mode};
                `RFS_FLD_COUNT:  rd_val = {16'h0000, dma_sel.count};
                `RFS_FLD_RELOAD: rd_val = {16'h0000, dma_sel.reload};
                `RFS_FLD_MEM:    rd_val = {8'h00, dma_sel.mem_ptr};
                `RFS_FLD_FIXED:  rd_val = {8'h00, dma_sel.fixed_ptr};
                default:         rd_val = `RFS_RST_BUS;
            endcase
        end else begin
            unique case (adr)
                `RFS_OFF_IP:   rd_val = {8'h00, ip_q};
                `RFS_OFF_VTB:  rd_val = {8'h00, vtb_q};
                `RFS_OFF_USP:  rd_val = {8'h00, user_stack_ptr_q};
                `RFS_OFF_ISP:  rd_val = {8'h00, irq_stack_ptr_q};
                `RFS_OFF_FLAG: rd_val = {16'h0000, flag_q};
                `RFS_OFF_SVF:  rd_val = {16'h0000, saved_flags_q};
                `RFS_OFF_SVP:  rd_val = {8'h00, saved_pointer_q};
                `RFS_OFF_VCT:  rd_val = {8'h00, fast_irq_target_q};
                `RFS_OFF_ASP:  rd_val = {8'h00, asp_q};
                default:       rd_val = `RFS_RST_BUS;
            endcase
        end
    end

    // Sequencer: storage reads are registered, so every access takes two edges (three for a pair)
    always_comb begin
        st_d   = st_q;
        hold_d = hold_q;
        unique case (st_q)
            RFS_IDLE: if (req) st_d = RFS_READ;
            RFS_READ: begin
                hold_d = mem_rd;
                st_d   = is_pair ? RFS_PAIR : RFS_ANS;
            end
            RFS_PAIR: st_d = RFS_ANS;
            RFS_ANS:  st_d = RFS_IDLE;
        endcase
        ack_d  = (st_d == RFS_ANS);
        dat_d  = ack_d ? rd_val : `RFS_RST_BUS;
        commit = req & wb_req.we & (st_q == RFS_READ) & ~is_pair & ~in_bank;
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            st_q   <= RFS_IDLE;
            ack_q  <= 1'b0;
            dat_q  <= `RFS_RST_BUS;
            hold_q <= `RFS_RST_ADDR;
        end else begin
            st_q   <= st_d;
            ack_q  <= ack_d;
            dat_q  <= dat_d;
            hold_q <= hold_d;
        end
    end

    // Core registers: bus writes first, core-side updates override them
    always_comb begin
        ip_d              = ip_q;
        vtb_d             = vtb_q;
        user_stack_ptr_d  = user_stack_ptr_q;
        irq_stack_ptr_d   = irq_stack_ptr_q;
        flag_d            = flag_q;
        saved_flags_d     = saved_flags_q;
        saved_pointer_d   = saved_pointer_q;
        fast_irq_target_d = fast_irq_target_q;
        if (commit) begin
            unique case (adr)
                `RFS_OFF_IP:   ip_d = merge(ip_q, wr_dat, wr_msk); // RQ9
                `RFS_OFF_VTB:  vtb_d = merge(vtb_q, wr_dat, wr_msk); // RQ10
                `RFS_OFF_USP:  user_stack_ptr_d = merge(user_stack_ptr_q, wr_dat, wr_msk); // RQ11
                `RFS_OFF_ISP:  irq_stack_ptr_d = merge(irq_stack_ptr_q, wr_dat, wr_msk); // RQ11
                `RFS_OFF_FLAG: flag_d = DW'(merge({8'h00, flag_q}, wr_dat, wr_msk)) & `RFS_FLAG_IMPL; // RQ13
                `RFS_OFF_SVF:  saved_flags_d = DW'(merge({8'h00, saved_flags_q}, wr_dat, wr_msk));
                `RFS_OFF_SVP:  saved_pointer_d = merge(saved_pointer_q, wr_dat, wr_msk);
                `RFS_OFF_VCT:  fast_irq_target_d = merge(fast_irq_target_q, wr_dat, wr_msk); // RQ16
                `RFS_OFF_ASP: begin
                    if (flag_q[`RFS_FLAG_STACK]) begin
                        user_stack_ptr_d = merge(user_stack_ptr_q, wr_dat, wr_msk); // RQ12
                    end else begin
                        irq_stack_ptr_d = merge(irq_stack_ptr_q, wr_dat, wr_msk); // RQ12
                    end
                end
                default: ;
            endcase
        end
        if (core_flag_we) begin
            flag_d = core_flag_d & `RFS_FLAG_IMPL; // RQ13
        end
        if (core_ip_we) begin
            ip_d = core_ip_d; // RQ9
        end
        // Fast interrupt saves the values from before this cycle's updates
        if (core_fint) begin
            saved_flags_d   = flag_q; // RQ14
            saved_pointer_d = ip_q; // RQ15
            ip_d            = fast_irq_target_q; // RQ16
        end
        // Registered copy so the selected pointer leaves from a flop
        asp_d = flag_d[`RFS_FLAG_STACK] ? user_stack_ptr_d : irq_stack_ptr_d; // RQ11 RQ12
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            ip_q              <= `RFS_RST_ADDR; // RQ22
            vtb_q             <= `RFS_RST_ADDR; // RQ22
            user_stack_ptr_q  <= `RFS_RST_ADDR; // RQ22
            irq_stack_ptr_q   <= `RFS_RST_ADDR; // RQ22
            asp_q             <= `RFS_RST_ADDR;
            flag_q            <= `RFS_RST_DATA; // RQ22
            saved_flags_q     <= `RFS_RST_DATA;
            saved_pointer_q   <= `RFS_RST_ADDR;
            fast_irq_target_q <= `RFS_RST_ADDR;
        end else begin
            ip_q              <= ip_d;
            vtb_q             <= vtb_d;
            user_stack_ptr_q  <= user_stack_ptr_d;
            irq_stack_ptr_q   <= irq_stack_ptr_d;
            asp_q             <= asp_d;
            flag_q            <= flag_d;
            saved_flags_q     <= saved_flags_d;
            saved_pointer_q   <= saved_pointer_d;
            fast_irq_target_q <= fast_irq_target_d;
        end
    end

    // Transfer channels; a reload request beats a bus write to the count
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        rfs_xfer_t xq_d;
        rfs_xfer_t xq_q;
        logic      hit;

        assign hit = req & wb_req.we & (st_q == RFS_READ) & is_dma & (adr[5] == 1'(c));

        always_comb begin
            xq_d = xq_q;
            if (hit) begin
                unique case (adr[4:2])
                    `RFS_FLD_MODE:   xq_d.mode = MW'(merge({16'h0000, xq_q.mode}, wr_dat, wr_msk)); // RQ17
                    `RFS_FLD_COUNT:  xq_d.count = DW'(merge({8'h00, xq_q.count}, wr_dat, wr_msk)); // RQ18
                    `RFS_FLD_RELOAD: xq_d.reload = DW'(merge({8'h00, xq_q.reload}, wr_dat, wr_msk)); // RQ19
                    `RFS_FLD_MEM:    xq_d.mem_ptr = merge(xq_q.mem_ptr, wr_dat, wr_msk); // RQ20
                    `RFS_FLD_FIXED:  xq_d.fixed_ptr = merge(xq_q.fixed_ptr, wr_dat, wr_msk); // RQ21
                    default: ;
                endcase
            end
            if (core_xfer_reload[c]) begin
                xq_d.count = xq_q.reload; // RQ19
            end
        end

        // Only the mode is reset; counts and addresses start undefined
        always_ff @(posedge clk) begin
            xq_q <= xq_d;
            if (!rstn) begin
                xq_q.mode <= `RFS_RST_MODE; // RQ22
            end
        end

        assign xfer_o[c] = xq_q;
    end

    // Outputs straight from flops
    assign wb_ack_o            = ack_q;
    assign wb_dat_o            = dat_q;
    assign instruction_pointer = ip_q;
    assign vector_table_base   = vtb_q;
    assign active_stack_ptr    = asp_q;
    assign flag_word           = flag_q;
    assign bank_sel            = flag_q[`RFS_FLAG_BANK]; // RQ2

endmodule

`default_nettype wire

// [verif/rfs_core_regs_properties.sv]
// Port-level assertions and covers for the CPU core register set.
`include "rfs_params.svh"
`default_nettype none

module rfs_core_props
    import rfs_pkg::*;
(
    input wire logic                  clk,
    input wire logic                  rstn,
    input wire rfs_wb_req_t           wb_req,
    input wire logic                  wb_ack_o,
    input wire logic [`RFS_BUS_W-1:0] wb_dat_o,
    input wire logic                  core_fint,
    input wire logic                  core_ip_we,
    input wire logic [`RFS_AW-1:0]    core_ip_d,
    input wire logic                  core_flag_we,
    input wire logic [`RFS_DW-1:0]    core_flag_d,
    input wire logic [`RFS_AW-1:0]    instruction_pointer,
    input wire logic [`RFS_DW-1:0]    flag_word,
    input wire logic                  bank_sel
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);

    // Pairs take one edge more: the halves are read or written in turn
    logic is_pair;
    assign is_pair = (wb_req.adr == 8'h20) || (wb_req.adr == 8'h24);

    ack_plain_a: assert property ($rose(wb_req.stb) && !is_pair |-> ##1 !wb_ack_o ##1 wb_ack_o)
        else $error("plain access ack not on third edge");
    ack_pair_a: assert property ($rose(wb_req.stb) && is_pair |-> ##2 !wb_ack_o ##1 wb_ack_o)
        else $error("pair access ack not on fourth edge");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    dat_quiet_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000)
        else $error("read data not zero outside ack");
    ip_load_a: assert property (core_ip_we && !core_fint |=> instruction_pointer == $past(core_ip_d))
        else $error("instruction pointer load lost");
    flag_mask_a: assert property (core_flag_we |=> flag_word == ($past(core_flag_d) & `RFS_FLAG_IMPL))
        else $error("flag load not masked to implemented bits");
    flag_resv_a: assert property ((flag_word & ~`RFS_FLAG_IMPL) == 16'h0000)
        else $error("reserved flag bit set");
    bank_map_a: assert property (bank_sel == flag_word[`RFS_FLAG_BANK])
        else $error("bank select differs from flag bit");
    reset_clr_a: assert property (disable iff (1'b0) !rstn |=> flag_word == 16'h0000 && !wb_ack_o)
        else $error("flag or ack not cleared by reset");

    // Main scenarios reached
    cover property (wb_ack_o && !wb_req.we);
    cover property (core_fint);
    cover property ($rose(bank_sel));
endmodule

bind rfs_core_regs rfs_core_props u_props (.clk, .rstn, .wb_req, .wb_ack_o, .wb_dat_o, .core_fint, .core_ip_we,
    .core_ip_d, .core_flag_we, .core_flag_d, .instruction_pointer, .flag_word, .bank_sel);

`default_nettype wire

// [verif/rfs_core_model.sv]
// Behavioural stand-in for the execution side that drives the core port.
`default_nettype none

module rfs_core_model (
    input  wire logic        clk,
    output logic             core_fint,
    output logic             core_ip_we,
    output logic [23:0]      core_ip_d,
    output logic             core_flag_we,
    output logic [15:0]      core_flag_d,
    output logic [1:0]       core_xfer_reload
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        {core_xfer_reload, core_flag_we, core_ip_we, core_fint} = 5'h00;
        core_ip_d = 24'h000000;
        core_flag_d = 16'h0000;
    end

    // One-cycle strobe, k = {reload, flag, ip, fint}; data then inverted to expose stale use
    task automatic fire(input logic [4:0] k, input logic [23:0] d);
        @(posedge clk);
        {core_xfer_reload, core_flag_we, core_ip_we, core_fint} <= k;
        core_ip_d <= d;
        core_flag_d <= d[15:0];
        @(posedge clk);
        {core_xfer_reload, core_flag_we, core_ip_we, core_fint} <= 5'h00;
        core_ip_d <= ~d;
        core_flag_d <= ~d[15:0];
        @(posedge clk);
    endtask
endmodule

`default_nettype wire

// [verif/test_cpu_core_register_set.sv]
// Self-checking bench for the CPU core register set.
`include "rfs_params.svh"
`default_nettype none
`define CHK(nm, ex, gt) begin num_checks++; if ((gt) !== (ex)) begin n_mismatch++; \
    $display("[FAIL] %s exp %h got %h", nm, ex, gt); end end

module test_cpu_core_register_set import rfs_pkg::*; ();
    timeunit 1ns;
    timeprecision 1ns;
    logic            clk = 1'b0;
    logic            rstn = 1'b0;
    rfs_wb_req_t     wb_req = '0;
    logic            wb_ack_o, core_fint, core_ip_we, core_flag_we, bank_sel;
    logic [2:0]      core_rd_idx = 3'h0;
    logic [1:0]      core_xfer_reload;
    logic [15:0]     core_flag_d, flag_word;
    logic [23:0]     core_ip_d, core_rd_data, instruction_pointer, vector_table_base, active_stack_ptr;
    logic [31:0]     wb_dat_o, r, mon_e;
    logic [31:0]     v [16];
    logic [31:0]     exp_q [$];
    rfs_xfer_t [1:0] xfer_o;
    int              seed = 92, n_mismatch = 0, num_checks = 0;
    localparam logic [31:0] FMASK [5] = '{32'h0000_00FF, 32'h0000_FFFF, 32'h0000_FFFF, 32'h00FF_FFFF, 32'h00FF_FFFF};

    rfs_core_regs #(.NCH(2)) u_dut (.clk, .rstn, .wb_req, .wb_ack_o, .wb_dat_o, .core_fint, .core_ip_we, .core_ip_d,
        .core_flag_we, .core_flag_d, .core_rd_idx, .core_xfer_reload, .core_rd_data, .instruction_pointer,
        .vector_table_base, .active_stack_ptr, .flag_word, .bank_sel, .xfer_o);
    rfs_core_model u_core (.clk, .core_fint, .core_ip_we, .core_ip_d, .core_flag_we, .core_flag_d, .core_xfer_reload);

    always #20 clk = ~clk;

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask

    // Classic single cycle; reads leave their expectation for the monitor
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] e = 32'h0,
                      input logic [3:0] s = 4'hF);
        int t;
        @(posedge clk);
        wb_req <= '{1'b1, 1'b1, w, s, a, d};
        if (!w) exp_q.push_back(e);
        t = 0;
        do begin @(posedge clk); t++; end while (wb_ack_o !== 1'b1 && t < 20);
        wb_req <= '0;
        if (t >= 20) `CHK("ack_wait", 1'b1, wb_ack_o)
    endtask

    // Read data is compared in the one cycle that ack stands
    always @(posedge clk) begin
        if (wb_ack_o === 1'b1 && !wb_req.we) begin
            mon_e = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hDEAD_BEEF;
            `CHK("rdata", mon_e, wb_dat_o)
        end
    end

    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        for (int a = 0; a <= 8'h48; a += 4) wb(1'b0, 8'(a), 32'h0);
        wb(1'b0, 8'h80, 32'h0);
        wb(1'b0, 8'hA0, 32'h0);
        for (int b = 0; b < 2; b++) begin
            wb(1'b1, 8'h38, {27'h0, 1'(b), 4'h0});
            for (int i = 0; i < 8; i++) begin
                r = $random(seed);
                v[b*8+i] = r & ((i < 4) ? 32'h0000_FFFF : 32'h00FF_FFFF);
                wb(1'b1, 8'(i * 4), r);
            end
        end
        for (int b = 0; b < 2; b++) begin
            wb(1'b1, 8'h38, {27'h0, 1'(b), 4'h0});
            `CHK("bank_sel", 1'(b), bank_sel)
            for (int i = 0; i < 8; i++) begin
                wb(1'b0, 8'(i * 4), 32'h0, v[b*8+i]);
                core_rd_idx <= 3'(i);
                repeat (2) @(posedge clk);
                `CHK("core_rd", v[b*8+i][23:0], core_rd_data)
            end
            wb(1'b0, 8'h20, 32'h0, {v[b*8+2][15:0], v[b*8][15:0]});
            wb(1'b0, 8'h24, 32'h0, {v[b*8+3][15:0], v[b*8+1][15:0]});
        end
        // Byte lanes of acc a and b, bank one still selected
        wb(1'b1, 8'h04, 32'h0000_5A00, 32'h0, 4'h2);
        wb(1'b0, 8'h04, 32'h0, {16'h0, 8'h5A, v[9][7:0]});
        wb(1'b1, 8'h00, 32'h0000_00A5, 32'h0, 4'h1);
        wb(1'b0, 8'h00, 32'h0, {16'h0, v[8][15:8], 8'hA5});
        wb(1'b1, 8'h30, 32'h0012_3457);
        wb(1'b1, 8'h34, 32'h00AB_CDEF);
        wb(1'b1, 8'h38, 32'hFFFF_FFFF);
        wb(1'b0, 8'h38, 32'h0, 32'h0000_70FF);
        `CHK("asp_user", 24'h123457, active_stack_ptr)
        wb(1'b1, 8'h38, 32'h0000_0000);
        `CHK("asp_irq", 24'hABCDEF, active_stack_ptr)
        wb(1'b1, 8'h48, 32'h0000_2468);
        wb(1'b0, 8'h34, 32'h0, 32'h0000_2468);
        // Fast interrupt saves flag and pointer, then jumps to the target
        r = $random(seed);
        wb(1'b1, 8'h44, r);
        wb(1'b1, 8'h2C, ~r);
        `CHK("vtb", ~r[23:0], vector_table_base)
        u_core.fire(5'h02, 24'h13579B);
        `CHK("ip_load", 24'h13579B, instruction_pointer)
        u_core.fire(5'h04, 24'h003085);
        u_core.fire(5'h01, 24'h000000);
        `CHK("ip_target", r[23:0], instruction_pointer)
        wb(1'b0, 8'h3C, 32'h0, 32'h0000_3085);
        wb(1'b0, 8'h40, 32'h0, 32'h0013_579B);
        for (int c = 0; c < 2; c++) begin
            for (int f = 0; f < 5; f++) begin
                r = $random(seed);
                v[f] = r & FMASK[f];
                wb(1'b1, 8'(8'h80 + c * 32 + f * 4), r);
            end
            for (int f = 0; f < 5; f++) wb(1'b0, 8'(8'h80 + c * 32 + f * 4), 32'h0, v[f]);
            `CHK("mode_out", v[0][7:0], xfer_o[c].mode)
            u_core.fire({2'(1 << c), 3'h0}, 24'h000000);
            `CHK("reloaded", v[2][15:0], xfer_o[c].count)
        end
        wb(1'b1, 8'h4C, 32'hFFFF_FFFF);
        wb(1'b0, 8'h4C, 32'h0, 32'h0);
        repeat (4) @(posedge clk);
        `CHK("pending", 0, exp_q.size())
        tally_and_finish();
    end

    // Hang guard at 50000 cycles, far past the few hundred cycles needed
    initial begin
        #2000000;
        n_mismatch++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
